// File: mcps_pkg.sv
// Constants for the master clock and programmable clock select block.
// Assumes one 200 MHz system clock and source clocks arriving as pins.
// Overview of operation
// - Two-bit source selector picks master clock source
// - Master prescaler divides by two to the code
// - Master divider: 1, 2, 4, 3; zero disables DDR
// - DDR system clock twice, DDR clock equals master
// - Halving bit halves the PLL A clock
// - Programmable clock selector picks one of four
// - Programmable prescaler divides by two to code
// - Slow or master select, only with selector zero
// - Enable register: ones enable, zeros ignored
// - Disable register: ones disable, zeros ignored
// - Status shows oscillator, locks and master ready
// - Programmable ready flag shows output readiness
// - Mask reads zero enabled, one disabled
// - Oscillator stable after count times eight slow
// - PLL A lock after programmed slow cycles
// - UTMI lock after programmed start-up time
`default_nettype none
package mcps_pkg;
  localparam logic [27:0] MCPS_MCK_ADDR = 28'hffffc30;
  localparam logic [27:0] MCPS_PCK_BASE = 28'hffffc40;
  localparam logic [27:0] MCPS_IER_ADDR = 28'hffffc60;
  localparam logic [27:0] MCPS_IDR_ADDR = 28'hffffc64;
  localparam logic [27:0] MCPS_SR_ADDR = 28'hffffc68;
  localparam logic [27:0] MCPS_IMR_ADDR = 28'hffffc6c;
  localparam logic [27:0] MCPS_START_ADDR = 28'hffffc70;
  localparam logic [27:0] MCPS_PLLA_ADDR = 28'hffffc74;
  localparam int MCPS_CSS_LSB = 0;
  localparam int MCPS_PRESCALER_CODE_LSB = 2;
  localparam int MCPS_MASTER_DIVIDER_LSB = 8;
  localparam int MCPS_HALVE_BIT = 12;
  localparam int MCPS_SLM_BIT = 8;
  localparam int MCPS_OSCEN_BIT = 0;
  localparam int MCPS_UTMIEN_BIT = 1;
  localparam int MCPS_OSCCNT_LSB = 8;
  localparam int MCPS_UTMICNT_LSB = 16;
  localparam int MCPS_PLLCNT_LSB = 0;
  localparam int MCPS_ST_OSC = 0;
  localparam int MCPS_ST_PLL_A_LOCK_FLAG = 1;
  localparam int MCPS_ST_MASTER_CLOCK_READY_FLAG = 3;
  localparam int MCPS_ST_UTMI_LOCK_FLAG = 6;
  localparam int MCPS_ST_PCK_LSB = 8;
  localparam logic [31:0] MCPS_IRQ_VALID = 32'h00000f4b;
  localparam logic [1:0] MCPS_SRC_SLOW = 2'h0;
  localparam logic [1:0] MCPS_SRC_MAIN = 2'h1;
  localparam logic [1:0] MCPS_SRC_PLLA = 2'h2;
  localparam logic [1:0] MCPS_SRC_UTMI = 2'h3;
  localparam logic [2:0] MCPS_PRESCALER_CODE_RSVD = 3'h7;
  localparam logic [1:0] MCPS_MASTER_DIVIDER_ONE = 2'h0;
  localparam logic [1:0] MCPS_MCK_SRC_RST = 2'h0;
  localparam logic [2:0] MCPS_PRESCALER_CODE_RST = 3'h0;
  localparam logic [1:0] MCPS_MASTER_DIVIDER_RST = 2'h0;
  localparam logic [7:0] MCPS_CNT_RST = 8'h00;
  localparam logic [31:0] MCPS_IRQ_EN_RST = 32'h00000000;
  localparam int MCPS_SLOW_SCALE_SHIFT = 3;
  typedef enum logic [1:0] {
    MCPS_MCK_CHANGE = 2'b00,
    MCPS_MCK_SETTLE = 2'b01,
    MCPS_MCK_READY = 2'b11
  } mcps_mck_state_t;
endpackage : mcps_pkg
`default_nettype wire

// File: mcps_clock_select.sv
// Master clock source, prescaler and divider, programmable clocks, interrupts.
// Assumes source clocks are far slower than clk; each rising edge becomes an enable.
//
// Decided for this implementation: the plain strobed port.
`default_nettype none
module mcps_clock_select
  import mcps_pkg::*;
#(
  parameter int NPROG = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [27:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic slowClockPin,
  input wire logic mainClockPin,
  input wire logic pllAClockPin,
  input wire logic utmiPllClockPin,
  output logic [31:0] rdata,
  output logic irq,
  output logic masterClock,
  output logic ddrSystemClock,
  output logic ddrClockOutput,
  output logic [NPROG-1:0] progClock
);

  function automatic logic [5:0] presLimit(input logic [2:0] code);
    presLimit = 6'((7'h1 << code) - 7'h1);
  endfunction : presLimit
  function automatic logic [1:0] divLimit(input logic [1:0] code);
    case (code)
      2'h0: divLimit = 2'h0;
      2'h1: divLimit = 2'h1;
      2'h2: divLimit = 2'h3;
      default: divLimit = 2'h2;
    endcase
  endfunction : divLimit
  function automatic logic pickEdge(input logic [1:0] code, input logic [3:0] edges);
    pickEdge = edges[code];
  endfunction : pickEdge
  function automatic logic [27:0] pckAddr(input int idx);
    pckAddr = MCPS_PCK_BASE + 28'(idx * 4);
  endfunction : pckAddr
  // Pin synchronisers and edge qualification
  logic [3:0] pins, syncA, syncB, syncC, pinLevel, pinRise, srcEdge;
  logic pllAPhase, pllAHalfEdge;
  assign pins = {utmiPllClockPin, pllAClockPin, mainClockPin, slowClockPin};
  assign pinRise = ~(syncB ^ syncC) & syncC & ~pinLevel;
  always_ff @(posedge clk) begin
    if (srst) begin
      syncA <= 4'h0;
      syncB <= 4'h0;
      syncC <= 4'h0;
      pinLevel <= 4'h0;
    end else begin
      syncA <= pins;
      syncB <= syncA;
      syncC <= syncB;
      pinLevel <= (syncB ^ syncC) & pinLevel | ~(syncB ^ syncC) & syncC;
    end
  end
  // Configuration registers
  logic [1:0] mckSource, mckDiv;
  logic [2:0] mckPres;
  logic pllAHalve, oscEnable, utmiEnable;
  logic [1:0] pckSource [NPROG];
  logic [2:0] pckPres [NPROG];
  logic pckSlowMaster [NPROG];
  logic [31:0] irqEnable;
  logic [7:0] oscCount, utmiCount, pllACount;
  logic wrMck, wrStart, wrPllA, mckCfgChange;
  assign wrMck = wr && addr == MCPS_MCK_ADDR;
  assign wrStart = wr && addr == MCPS_START_ADDR;
  assign wrPllA = wr && addr == MCPS_PLLA_ADDR;
  assign mckCfgChange = wrMck && (wdata[MCPS_CSS_LSB+:2] != mckSource
      || wdata[MCPS_PRESCALER_CODE_LSB+:3] != mckPres || wdata[MCPS_MASTER_DIVIDER_LSB+:2] != mckDiv);

  always_ff @(posedge clk) begin
    if (srst) begin
      mckSource <= MCPS_MCK_SRC_RST;
      mckPres <= MCPS_PRESCALER_CODE_RST;
      mckDiv <= MCPS_MASTER_DIVIDER_RST;
      pllAHalve <= 1'b0;
    end else if (wrMck) begin
      mckSource <= wdata[MCPS_CSS_LSB+:2];
      mckPres <= wdata[MCPS_PRESCALER_CODE_LSB+:3];
      mckDiv <= wdata[MCPS_MASTER_DIVIDER_LSB+:2];
      pllAHalve <= wdata[MCPS_HALVE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < NPROG; i++) begin
      if (srst) begin
        pckSource[i] <= MCPS_SRC_SLOW;
        pckPres[i] <= MCPS_PRESCALER_CODE_RST;
        pckSlowMaster[i] <= 1'b0;
      end else if (wr && addr == pckAddr(i)) begin
        pckSource[i] <= wdata[MCPS_CSS_LSB+:2];
        pckPres[i] <= wdata[MCPS_PRESCALER_CODE_LSB+:3];
        pckSlowMaster[i] <= wdata[MCPS_SLM_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irqEnable <= MCPS_IRQ_EN_RST;
    end else if (wr && addr == MCPS_IER_ADDR) begin
      irqEnable <= irqEnable | (wdata & MCPS_IRQ_VALID);
    end else if (wr && addr == MCPS_IDR_ADDR) begin
      irqEnable <= irqEnable & ~wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      oscEnable <= 1'b0;
      utmiEnable <= 1'b0;
      oscCount <= MCPS_CNT_RST;
      utmiCount <= MCPS_CNT_RST;
      pllACount <= MCPS_CNT_RST;
    end else begin
      if (wrStart) begin
        oscEnable <= wdata[MCPS_OSCEN_BIT];
        utmiEnable <= wdata[MCPS_UTMIEN_BIT];
        oscCount <= wdata[MCPS_OSCCNT_LSB+:8];
        utmiCount <= wdata[MCPS_UTMICNT_LSB+:8];
      end
      if (wrPllA) begin
        pllACount <= wdata[MCPS_PLLCNT_LSB+:8];
      end
    end
  end
  // PLL A halving stage shared by both selectors
  always_ff @(posedge clk) begin
    if (srst) begin
      pllAPhase <= 1'b0;
    end else if (pinRise[MCPS_SRC_PLLA]) begin
      pllAPhase <= ~pllAPhase;
    end
  end

  assign pllAHalfEdge = pinRise[MCPS_SRC_PLLA] && (!pllAHalve || pllAPhase);
  assign srcEdge = {pinRise[MCPS_SRC_UTMI], pllAHalfEdge, pinRise[MCPS_SRC_MAIN],
      pinRise[MCPS_SRC_SLOW]};
  // Master path: source, prescaler, divider
  logic mckSrcEdge, mckPresTick, masterEn, ddrSysEn, masterTick;
  logic [5:0] mckPresCnt;
  logic [1:0] mckDivCnt, mckDivMid;
  mcps_mck_state_t mckState, next_mckState;
  assign mckSrcEdge = pickEdge(mckSource, srcEdge);
  assign mckPresTick = mckSrcEdge && mckPres != MCPS_PRESCALER_CODE_RSVD
      && mckPresCnt == presLimit(mckPres);
  assign mckDivMid = (divLimit(mckDiv) - 2'h1) >> 1;
  assign masterEn = mckPresTick && mckDivCnt == divLimit(mckDiv);
  assign ddrSysEn = mckPresTick && mckDiv != MCPS_MASTER_DIVIDER_ONE
      && (mckDivCnt == divLimit(mckDiv) || mckDivCnt == mckDivMid);
  assign masterTick = masterEn && mckState != MCPS_MCK_CHANGE;

  always_ff @(posedge clk) begin
    if (srst || mckCfgChange) begin
      mckPresCnt <= 6'h00;
    end else if (mckSrcEdge) begin
      mckPresCnt <= mckPresTick ? 6'h00 : mckPresCnt + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || mckCfgChange) begin
      mckDivCnt <= 2'h0;
    end else if (mckPresTick) begin
      mckDivCnt <= masterEn ? 2'h0 : mckDivCnt + 2'h1;
    end
  end
  // Ready drops on a change, returns after two master half periods
  always_comb begin
    next_mckState = mckState;
    case (mckState)
      MCPS_MCK_CHANGE: if (masterEn) next_mckState = MCPS_MCK_SETTLE;
      MCPS_MCK_SETTLE: if (masterEn) next_mckState = MCPS_MCK_READY;
      MCPS_MCK_READY: next_mckState = MCPS_MCK_READY;
      default: next_mckState = MCPS_MCK_CHANGE;
    endcase
    if (mckCfgChange) begin
      next_mckState = MCPS_MCK_CHANGE;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mckState <= MCPS_MCK_CHANGE;
    end else begin
      mckState <= next_mckState;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      masterClock <= 1'b0;
      ddrClockOutput <= 1'b0;
      ddrSystemClock <= 1'b0;
    end else if (mckDiv == MCPS_MASTER_DIVIDER_ONE) begin
      masterClock <= masterClock ^ masterTick;
      ddrClockOutput <= 1'b0;
      ddrSystemClock <= 1'b0;
    end else if (mckState != MCPS_MCK_CHANGE) begin
      masterClock <= masterClock ^ masterEn;
      ddrClockOutput <= ddrClockOutput ^ masterEn;
      ddrSystemClock <= ddrSystemClock ^ ddrSysEn;
    end
  end
  // Programmable clocks
  logic [NPROG-1:0] pckEdge, pckTick, pckReady;
  logic [5:0] pckCnt [NPROG];
  always_comb begin
    for (int i = 0; i < NPROG; i++) begin
      if (pckSource[i] == MCPS_SRC_SLOW && pckSlowMaster[i]) begin
        pckEdge[i] = masterTick;
      end else begin
        pckEdge[i] = pickEdge(pckSource[i], srcEdge);
      end
      pckTick[i] = pckEdge[i] && pckPres[i] != MCPS_PRESCALER_CODE_RSVD
          && pckCnt[i] == presLimit(pckPres[i]);
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < NPROG; i++) begin
      if (srst) begin
        pckCnt[i] <= 6'h00;
        pckReady[i] <= 1'b0;
        progClock[i] <= 1'b0;
      end else if (wr && addr == pckAddr(i)) begin
        pckCnt[i] <= 6'h00;
        pckReady[i] <= 1'b0;
      end else if (pckEdge[i]) begin
        pckCnt[i] <= pckTick[i] ? 6'h00 : pckCnt[i] + 6'h01;
        pckReady[i] <= pckReady[i] | pckTick[i];
        progClock[i] <= progClock[i] ^ pckTick[i];
      end
    end
  end
  // Start-up timers on the slow clock
  logic [10:0] oscTimer, utmiTimer;
  logic [7:0] pllATimer;
  logic oscStable, utmiLock, pllALock, slowEdge;
  assign slowEdge = pinRise[MCPS_SRC_SLOW];

  always_ff @(posedge clk) begin
    if (srst || wrStart) begin
      oscTimer <= 11'h000;
      oscStable <= 1'b0;
    end else if (oscEnable && slowEdge && !oscStable) begin
      oscStable <= oscTimer == (11'(oscCount) << MCPS_SLOW_SCALE_SHIFT);
      oscTimer <= oscTimer + 11'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || wrStart) begin
      utmiTimer <= 11'h000;
      utmiLock <= 1'b0;
    end else if (utmiEnable && slowEdge && !utmiLock) begin
      utmiLock <= utmiTimer == (11'(utmiCount) << MCPS_SLOW_SCALE_SHIFT);
      utmiTimer <= utmiTimer + 11'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || wrPllA) begin
      pllATimer <= 8'h00;
      pllALock <= 1'b0;
    end else if (slowEdge && !pllALock) begin
      pllALock <= pllATimer == pllACount;
      pllATimer <= pllATimer + 8'h01;
    end
  end
  // Status, interrupt and read-back
  logic [31:0] statusWord, readWord;
  always_comb begin
    statusWord = 32'h00000000;
    statusWord[MCPS_ST_OSC] = oscStable;
    statusWord[MCPS_ST_PLL_A_LOCK_FLAG] = pllALock;
    statusWord[MCPS_ST_MASTER_CLOCK_READY_FLAG] = mckState == MCPS_MCK_READY;
    statusWord[MCPS_ST_UTMI_LOCK_FLAG] = utmiLock;
    statusWord[MCPS_ST_PCK_LSB+:NPROG] = pckReady;
  end

  always_comb begin
    readWord = 32'h00000000;
    if (addr == MCPS_MCK_ADDR) begin
      readWord[MCPS_CSS_LSB+:2] = mckSource;
      readWord[MCPS_PRESCALER_CODE_LSB+:3] = mckPres;
      readWord[MCPS_MASTER_DIVIDER_LSB+:2] = mckDiv;
      readWord[MCPS_HALVE_BIT] = pllAHalve;
    end else if (addr == MCPS_SR_ADDR) begin
      readWord = statusWord;
    end else if (addr == MCPS_IMR_ADDR) begin
      readWord = ~irqEnable & MCPS_IRQ_VALID;
    end else if (addr == MCPS_START_ADDR) begin
      readWord[MCPS_OSCEN_BIT] = oscEnable;
      readWord[MCPS_UTMIEN_BIT] = utmiEnable;
      readWord[MCPS_OSCCNT_LSB+:8] = oscCount;
      readWord[MCPS_UTMICNT_LSB+:8] = utmiCount;
    end else if (addr == MCPS_PLLA_ADDR) begin
      readWord[MCPS_PLLCNT_LSB+:8] = pllACount;
    end
    for (int i = 0; i < NPROG; i++) begin
      if (addr == pckAddr(i)) begin
        readWord[MCPS_CSS_LSB+:2] = pckSource[i];
        readWord[MCPS_PRESCALER_CODE_LSB+:3] = pckPres[i];
        readWord[MCPS_SLM_BIT] = pckSlowMaster[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      rdata <= rd ? readWord : 32'h00000000;
      irq <= |(statusWord & irqEnable);
    end
  end
  // Checks
  property p_imr;
    @(posedge clk) disable iff (srst)
      rd && addr == MCPS_IMR_ADDR |=> rdata == (~$past(irqEnable) & MCPS_IRQ_VALID);
  endproperty
  a_imr: assert property (p_imr) else $error("mask read polarity wrong");
  property p_ier;
    @(posedge clk) disable iff (srst)
      wr && addr == MCPS_IER_ADDR |=> ((irqEnable & $past(wdata) & MCPS_IRQ_VALID)
      == ($past(wdata) & MCPS_IRQ_VALID)) && ((irqEnable & ~$past(wdata))
      == ($past(irqEnable) & ~$past(wdata)));
  endproperty
  a_ier: assert property (p_ier) else $error("enable write wrong");
  property p_idr;
    @(posedge clk) disable iff (srst)
      wr && addr == MCPS_IDR_ADDR |=> (irqEnable & $past(wdata)) == 32'h00000000;
  endproperty
  a_idr: assert property (p_idr) else $error("disable write wrong");
  property p_irq;
    @(posedge clk) disable iff (srst)
      wr && addr == MCPS_IDR_ADDR && wdata == 32'hffffffff |=> ##1 !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq stays after full disable");
  property p_mck_clear;
    @(posedge clk) disable iff (srst)
      mckCfgChange |=> !statusWord[MCPS_ST_MASTER_CLOCK_READY_FLAG] && !masterTick;
  endproperty
  a_mck_clear: assert property (p_mck_clear) else $error("ready kept on change");
  property p_ddr_off;
    @(posedge clk) disable iff (srst)
      (mckDiv == MCPS_MASTER_DIVIDER_ONE)[*2] |-> !ddrSystemClock && !ddrClockOutput;
  endproperty
  a_ddr_off: assert property (p_ddr_off) else $error("ddr clock with divide one");
  property p_ddr_rel;
    @(posedge clk) disable iff (srst)
      masterTick && mckDiv != MCPS_MASTER_DIVIDER_ONE
      |=> $changed(ddrClockOutput) && $changed(ddrSystemClock);
  endproperty
  a_ddr_rel: assert property (p_ddr_rel) else $error("ddr system edge missing");
  property p_pck_main;
    @(posedge clk) disable iff (srst)
      pckSource[0] == MCPS_SRC_MAIN |-> pckEdge[0] == pinRise[MCPS_SRC_MAIN];
  endproperty
  a_pck_main: assert property (p_pck_main) else $error("prog source main wrong");
  property p_pck_slm;
    @(posedge clk) disable iff (srst)
      pckSource[0] == MCPS_SRC_SLOW && !pckSlowMaster[0] |-> pckEdge[0] == slowEdge;
  endproperty
  a_pck_slm: assert property (p_pck_slm) else $error("prog slow select wrong");
  property p_pck_rdy;
    @(posedge clk) disable iff (srst)
      wr && addr == pckAddr(0) |=> !statusWord[MCPS_ST_PCK_LSB];
  endproperty
  a_pck_rdy: assert property (p_pck_rdy) else $error("prog ready kept");
  property p_osc;
    @(posedge clk) disable iff (srst)
      wrStart && !wdata[MCPS_OSCEN_BIT] |=> !oscStable [*2];
  endproperty
  a_osc: assert property (p_osc) else $error("osc stable while disabled");
  property p_halve;
    @(posedge clk) disable iff (srst)
      !pllAHalve |-> pllAHalfEdge == pinRise[MCPS_SRC_PLLA];
  endproperty
  a_halve: assert property (p_halve) else $error("pll a passed wrongly");
  c_ready: cover property (@(posedge clk) disable iff (srst) mckState == MCPS_MCK_READY);
  c_ddr: cover property (@(posedge clk) disable iff (srst) $rose(ddrSystemClock));
  c_irq: cover property (@(posedge clk) disable iff (srst) $rose(irq));
  c_pck: cover property (@(posedge clk) disable iff (srst) $rose(pckReady[0]));

endmodule : mcps_clock_select
`default_nettype wire

// File: tb_top.sv
// Self-checking bench: registers, status flags, master and programmable clocks.
// Assumes mcps_pkg is compiled first; the bench itself makes all four source clocks.
`default_nettype none
module tb_top
  import mcps_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, srst, wr, rd, irq, masterClock, ddrSystemClock, ddrClockOutput;
  logic [27:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] progClock;
  logic [3:0] pin = 4'h0;
  int pc[4] = '{0, 0, 0, 0};
  int half[4] = '{8, 4, 6, 5};
  int fails, n_tests, p;

  mcps_clock_select #(.NPROG(4)) dut_u (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .slowClockPin(pin[0]), .mainClockPin(pin[1]), .pllAClockPin(pin[2]),
    .utmiPllClockPin(pin[3]), .rdata(rdata), .irq(irq), .masterClock(masterClock),
    .ddrSystemClock(ddrSystemClock), .ddrClockOutput(ddrClockOutput),
    .progClock(progClock)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Source clocks: slow 16, main 8, PLL A 12, UTMI 10 cycles of clk
  always @(posedge clk) begin
    for (int k = 0; k < 4; k++) begin
      if (pc[k] == half[k] - 1) begin
        pc[k] <= 0;
        pin[k] <= ~pin[k];
      end else begin
        pc[k] <= pc[k] + 1;
      end
    end
  end

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wrReg(input logic [27:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrReg

  task automatic rdReg(input logic [27:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rdReg

  task automatic waitBit(input int b);
    int n;
    n = 0;
    rdReg(MCPS_SR_ADDR, v);
    while (v[b] !== 1'b1 && n < 2000) begin
      rdReg(MCPS_SR_ADDR, v);
      n++;
    end
  endtask : waitBit

  function automatic logic sigOf(input int w);
    case (w)
      0: return masterClock;
      1: return ddrSystemClock;
      2: return ddrClockOutput;
      default: return progClock[w-3];
    endcase
  endfunction : sigOf

  // Counts clk edges up to the next rising edge of the chosen output
  task automatic waitRise(input int w, output int n);
    logic prev;
    logic cur;
    n = 0;
    prev = sigOf(w);
    cur = prev;
    while (!(prev === 1'b0 && cur === 1'b1) && n < 5000) begin
      @(posedge clk);
      #1;
      prev = cur;
      cur = sigOf(w);
      n++;
    end
  endtask : waitRise

  task automatic measure(input int w, output int n);
    waitRise(w, n);
    waitRise(w, n);
  endtask : measure

  function automatic logic [31:0] master_clock(input int c, input int s, input int d, input int h);
    return 32'(c) | 32'(s) << 2 | 32'(d) << 8 | 32'(h) << 12;
  endfunction : master_clock

  task automatic setMck(input logic [31:0] val, input int per);
    wrReg(MCPS_MCK_ADDR, val);
    rdReg(MCPS_SR_ADDR, v);
    check(v[3], 1'b0);
    rdReg(MCPS_MCK_ADDR, v);
    check(v, val);
    waitBit(3);
    check(v[3], 1'b1);
    measure(0, p);
    check(p, per);
  endtask : setMck

  task automatic setPck(input int i, input logic [31:0] val, input int per, input bit z);
    wrReg(MCPS_PCK_BASE + 28'(4 * i), val);
    rdReg(MCPS_SR_ADDR, v);
    if (z) begin
      check(v[8+i], 1'b0);
    end
    rdReg(MCPS_PCK_BASE + 28'(4 * i), v);
    check(v, val);
    waitBit(8 + i);
    check(v[8+i], 1'b1);
    measure(3 + i, p);
    check(p, per);
  endtask : setPck

  task automatic tReset();
    rdReg(MCPS_IMR_ADDR, v);
    check(v, 32'h00000f4b);
    @(posedge clk);
    #1;
    check(rdata, 32'h00000000);
    check(irq, 1'b0);
    rdReg(MCPS_MCK_ADDR, v);
    check(v, 32'h00000000);
    rdReg(MCPS_IER_ADDR, v);
    check(v, 32'h00000000);
    rdReg(28'hffffc50, v);
    check(v, 32'h00000000);
    $display("test reset done");
  endtask : tReset

  task automatic tMask();
    logic [27:0] a[6] = '{MCPS_IER_ADDR, MCPS_IER_ADDR, MCPS_IDR_ADDR, MCPS_IDR_ADDR,
      MCPS_IER_ADDR, MCPS_IDR_ADDR};
    logic [31:0] d[6] = '{32'h0000000b, 32'h0, 32'h1, 32'h0, 32'h00000f40, 32'hffffffff};
    logic [31:0] e[6] = '{32'hf40, 32'hf40, 32'hf41, 32'hf41, 32'h001, 32'hf4b};
    for (int k = 0; k < 6; k++) begin
      wrReg(a[k], d[k]);
      rdReg(MCPS_IMR_ADDR, v);
      check(v, e[k]);
    end
    check(irq, 1'b0);
    $display("test mask done");
  endtask : tMask

  task automatic tFlags();
    wrReg(MCPS_START_ADDR, 32'h00000103);
    wrReg(MCPS_PLLA_ADDR, 32'h00000004);
    wrReg(MCPS_IER_ADDR, 32'h00000001);
    rdReg(MCPS_SR_ADDR, v);
    check(v[1:0], 2'b00);
    repeat (40) @(posedge clk);
    rdReg(MCPS_SR_ADDR, v);
    check(v[6], 1'b1);
    check(v[1:0], 2'b00);
    check(irq, 1'b0);
    repeat (60) @(posedge clk);
    rdReg(MCPS_SR_ADDR, v);
    check(v[1:0], 2'b10);
    waitBit(0);
    check(v[0], 1'b1);
    @(posedge clk);
    #1;
    check(irq, 1'b1);
    wrReg(MCPS_IDR_ADDR, 32'h00000001);
    @(posedge clk);
    #1;
    check(irq, 1'b0);
    wrReg(MCPS_IER_ADDR, 32'h00000040);
    @(posedge clk);
    #1;
    check(irq, 1'b1);
    wrReg(MCPS_IDR_ADDR, 32'h00000040);
    @(posedge clk);
    #1;
    check(irq, 1'b0);
    wrReg(MCPS_START_ADDR, 32'h00000000);
    repeat (40) @(posedge clk);
    rdReg(MCPS_SR_ADDR, v);
    check(v[0], 1'b0);
    check(v[6], 1'b0);
    $display("test flags done");
  endtask : tFlags

  task automatic tMaster();
    int dv[4] = '{1, 2, 4, 3};
    logic acc;
    setMck(master_clock(1, 0, 0, 0), 16);
    acc = 1'b0;
    repeat (40) begin
      @(posedge clk);
      #1;
      acc = acc | ddrSystemClock | ddrClockOutput;
    end
    check(acc, 1'b0);
    for (int d = 1; d < 4; d++) begin
      setMck(master_clock(1, 0, d, 0), 16 * dv[d]);
      measure(2, p);
      check(p, 16 * dv[d]);
      // System clock is uneven when dividing by three
      if (d < 3) begin
        measure(1, p);
        check(p, 8 * dv[d]);
      end
    end
    for (int s = 1; s < 7; s++) begin
      setMck(master_clock(1, s, 1, 0), 32 << s);
    end
    setMck(master_clock(1, 0, 1, 0), 32);
    setMck(master_clock(2, 0, 1, 0), 48);
    setMck(master_clock(2, 1, 1, 1), 192);
    setMck(master_clock(3, 0, 1, 1), 40);
    setMck(master_clock(0, 0, 1, 1), 64);
    $display("test master done");
  endtask : tMaster

  task automatic tProg();
    for (int s = 0; s < 7; s++) begin
      setPck(0, 32'(1 | s << 2), 16 << s, s > 1);
    end
    setPck(1, 32'h00000000, 32, 1'b0);
    setPck(1, 32'h00000100, 64, 1'b0);
    setPck(1, 32'h00000101, 16, 1'b0);
    setPck(1, 32'h00000002, 48, 1'b0);
    setPck(3, 32'h00000003, 20, 1'b0);
    setPck(2, 32'h00000001, 16, 1'b0);
    wrReg(MCPS_PCK_BASE + 28'h0000008, 32'h0000001d);
    wrReg(MCPS_MCK_ADDR, master_clock(0, 7, 1, 1));
    repeat (200) @(posedge clk);
    rdReg(MCPS_SR_ADDR, v);
    check(v[10], 1'b0);
    check(v[3], 1'b0);
    $display("test prog done");
  endtask : tProg

  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    conclude();
  end

  initial begin
    srst = 1'b1;
    addr = 28'h0000000;
    wdata = 32'h00000000;
    wr = 1'b0;
    rd = 1'b0;
    fails = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    tReset();
    tMask();
    tFlags();
    tMaster();
    tProg();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
